// ### mdu_regs.vh
// Constants for the multiply/divide co-processor
`ifndef MDU_REGS_VH
`define MDU_REGS_VH
// Register select codes on the special-function-register port
`define MDU_SEL_B0      3'h0
`define MDU_SEL_B1      3'h1
`define MDU_SEL_B2      3'h2
`define MDU_SEL_B3      3'h3
`define MDU_SEL_B4      3'h4
`define MDU_SEL_B5      3'h5
`define MDU_SEL_CTRL    3'h6
// Control register fields
`define MDU_CTRL_ERR    7
`define MDU_CTRL_OVF    6
`define MDU_CTRL_DIR    5
`define MDU_CTRL_CNT_HI 4
// Reset values
`define MDU_RST_BYTE    8'h00
`define MDU_RST_CNT     5'h00
// Execution times in clock cycles
`define MDU_CYC_DIV32   5'h11
`define MDU_CYC_DIV16   5'h09
`define MDU_CYC_MUL     5'h0B
`define MDU_CYC_SHBASE  5'h02
`define MDU_CYC_NRBASE  5'h03
`define MDU_CYC_SHMAX   5'h12
`endif

// ### mdu_bytes.v
// Six-byte operand/result store with registered read data
`timescale 1ns/1ps
`include "mdu_regs.vh"
module mdu_bytes (
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire        wr_en,
    input  wire [2:0]  wr_sel,
    input  wire [7:0]  wr_data,
    input  wire        ld_en,
    input  wire [47:0] ld_data,
    input  wire [2:0]  rd_sel,
    output reg  [7:0]  rd_data,
    output wire [47:0] all_data
);
    reg [7:0] mem [0:5];
    integer   i;

    assign all_data = {mem[5], mem[4], mem[3], mem[2], mem[1], mem[0]};

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            for (i = 0; i < 6; i = i + 1) begin
                mem[i] <= `MDU_RST_BYTE;
            end
            rd_data <= `MDU_RST_BYTE;
        end else begin
            if (ld_en) begin
                for (i = 0; i < 6; i = i + 1) begin
                    mem[i] <= ld_data[i*8 +: 8];
                end
            end else if (wr_en && wr_sel <= `MDU_SEL_B5) begin
                mem[wr_sel] <= wr_data;
            end
            if (rd_sel <= `MDU_SEL_B5) begin
                rd_data <= mem[rd_sel];
            end else begin
                rd_data <= `MDU_RST_BYTE;
            end
        end
    end
endmodule // mdu_bytes

// ### mdu_arith_coprocessor.v
// Multiply/divide/shift/normalize co-processor on the SFR port
//
// Operation
// - Closing write to byte five or control register starts the calculation.
// - Byte two or three written in the sequence selects 32/16 division.
// - Byte four selects 16/16 division; byte one selects 16x16 multiply.
// - Control write with zero count normalizes; nonzero count shifts that far.
// - Unit computes on its own; processor is never stalled.
// - Division 32/16 takes 17 cycles, 16/16 takes 9, multiply 11.
// - Shift takes 3 cycles at count one up to 18 at thirty-one.
// - Normalize takes 4 to 19 cycles depending on shifts needed.
// - Results land in documented bytes; last read ends the calculation.
// - Normalize shifts left until top bit set, stores shift count.
// - Shift direction from control bit five, zeros shifted in.
// - Error detection arms on byte zero write, disarms on final read.
// - Any write during execution sets the sequence-error flag.
// - Byte read during armed execution sets error flag; calculation continues.
// - Error flag is read-only, cleared by reading the control register.
// - Overflow on divide by zero, product above 0000FFFF, normalized input.
// - Other operations clear overflow; processor writes never touch it.
// - Overflow at control bit six, direction at bit five.
`timescale 1ns/1ps
`include "mdu_regs.vh"
module mdu_arith_coprocessor (
    input  wire       sys_clk,
    input  wire       sys_rst,
    input  wire       sfr_wr,
    input  wire       sfr_rd,
    input  wire [2:0] sfr_sel,
    input  wire [7:0] sfr_wdata,
    output wire [7:0] sfr_rdata,
    output wire       busy
);
    // ****************************************************************
    // Sequencing state
    // ****************************************************************
    localparam ST_IDLE = 3'b001;
    localparam ST_LOAD = 3'b010;
    localparam ST_EXEC = 3'b100;

    localparam OP_DIV32 = 5'b00001;
    localparam OP_DIV16 = 5'b00010;
    localparam OP_MUL   = 5'b00100;
    localparam OP_SHIFT = 5'b01000;
    localparam OP_NORM  = 5'b10000;

    reg  [2:0]  state;
    reg  [4:0]  op;
    reg         seen_wide;
    reg         seen_b1;
    reg         seen_b4;
    reg         armed;
    reg         err_flag;
    reg         ovf_flag;
    reg         dir_right;
    reg  [4:0]  shift_count;
    reg  [4:0]  cyc_left;
    reg  [47:0] result;
    reg         res_ovf;
    reg  [4:0]  res_cnt;
    reg         ld_en;
    reg  [7:0]  ctrl_rdata;
    reg         rd_ctrl_q;
    wire [7:0]  byte_rdata;
    wire [47:0] all_data;

    wire wr_byte = sfr_wr && (sfr_sel <= `MDU_SEL_B5);
    wire wr_ctrl = sfr_wr && (sfr_sel == `MDU_SEL_CTRL);
    wire rd_byte = sfr_rd && (sfr_sel <= `MDU_SEL_B5);
    wire rd_ctrl = sfr_rd && (sfr_sel == `MDU_SEL_CTRL);
    wire exec    = (state == ST_EXEC);

    // Store writes are blocked while executing so the result is not corrupted
    wire store_wr = wr_byte && !exec;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    function [4:0] lead_zeros;
        input [31:0] v;
        integer k;
        reg     found;
        begin
            lead_zeros = 5'h00;
            found      = 1'b0;
            for (k = 31; k >= 0; k = k - 1) begin
                if (!found && v[k]) begin
                    found = 1'b1;
                end else if (!found) begin
                    lead_zeros = lead_zeros + 5'h01;
                end
            end
        end
    endfunction

    function [31:0] divide;
        input [31:0] n;
        input [15:0] d;
        begin
            divide = (d == 16'h0000) ? 32'h0000_0000 : n / {16'h0000, d};
        end
    endfunction

    function [15:0] modulo;
        input [31:0] n;
        input [15:0] d;
        reg   [31:0] r;
        begin
            r      = (d == 16'h0000) ? 32'h0000_0000 : n % {16'h0000, d};
            modulo = r[15:0];
        end
    endfunction

    mdu_bytes u_bytes (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .wr_en    (store_wr),
        .wr_sel   (sfr_sel),
        .wr_data  (sfr_wdata),
        .ld_en    (ld_en),
        .ld_data  (result),
        .rd_sel   (sfr_sel),
        .rd_data  (byte_rdata),
        .all_data (all_data)
    );

    // ****************************************************************
    // Result computation at start
    // ****************************************************************
    // The closing byte five write reaches the store only on the start edge itself
    wire [47:0] op_data = (wr_byte && sfr_sel == `MDU_SEL_B5) ?
                          {sfr_wdata, all_data[39:0]} : all_data;
    wire [31:0] val32  = op_data[31:0];
    wire [15:0] divsr  = op_data[47:32];
    wire [31:0] prod   = op_data[15:0] * op_data[47:32];
    wire [4:0]  lz     = lead_zeros(val32);
    reg  [47:0] next_result;
    reg         next_ovf;
    reg  [4:0]  next_cnt;
    reg  [4:0]  next_cyc;
    reg  [4:0]  next_op;

    always @* begin
        next_result = op_data;
        next_ovf    = 1'b0;
        next_cnt    = shift_count;
        next_cyc    = `MDU_CYC_MUL;
        next_op     = OP_MUL;
        if (wr_ctrl) begin
            if (sfr_wdata[`MDU_CTRL_CNT_HI:0] == 5'h00) begin
                next_op = OP_NORM;
                next_ovf = val32[31];
                next_result[31:0] = val32 << lz;
                next_cnt = lz;
                next_cyc = `MDU_CYC_NRBASE + {1'b0, lz[4:1]} +
                           {4'h0, (lz[0] | (lz == 5'h00))};
            end else begin
                next_op = OP_SHIFT;
                next_cnt = sfr_wdata[`MDU_CTRL_CNT_HI:0];
                if (sfr_wdata[`MDU_CTRL_DIR]) begin
                    next_result[31:0] = val32 >> sfr_wdata[`MDU_CTRL_CNT_HI:0];
                end else begin
                    next_result[31:0] = val32 << sfr_wdata[`MDU_CTRL_CNT_HI:0];
                end
                next_cyc = `MDU_CYC_SHBASE + sfr_wdata[4:1] + {4'h0, sfr_wdata[0]};
            end
        end else if (seen_wide) begin
            next_op = OP_DIV32;
            next_result = {modulo(val32, divsr), divide(val32, divsr)};
            next_ovf = (divsr == 16'h0000);
            next_cyc = `MDU_CYC_DIV32;
        end else if (seen_b4 && !seen_b1) begin
            next_op = OP_DIV16;
            next_result = {modulo({16'h0000, op_data[15:0]}, divsr),
                           divide({16'h0000, op_data[15:0]}, divsr)};
            next_result[31:16] = 16'h0000;
            next_ovf = (divsr == 16'h0000);
            next_cyc = `MDU_CYC_DIV16;
        end else begin
            next_result = {op_data[47:32], prod};
            next_ovf = (prod > 32'h0000_FFFF);
            next_cyc = `MDU_CYC_MUL;
        end
    end

    // ****************************************************************
    // Sequencer and flags
    // ****************************************************************
    wire start_ok = (state == ST_LOAD) &&
                    ((wr_byte && sfr_sel == `MDU_SEL_B5) || wr_ctrl);
    wire final_rd = rd_byte &&
                    (((op == OP_DIV32 || op == OP_DIV16) && sfr_sel == `MDU_SEL_B5) ||
                     ((op == OP_MUL || op == OP_SHIFT || op == OP_NORM) &&
                      sfr_sel == `MDU_SEL_B3));
    wire err_set  = (exec && (wr_byte || wr_ctrl)) || (exec && armed && rd_byte);

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state       <= ST_IDLE;
            op          <= OP_MUL;
            seen_wide   <= 1'b0;
            seen_b1     <= 1'b0;
            seen_b4     <= 1'b0;
            armed       <= 1'b0;
            err_flag    <= 1'b0;
            ovf_flag    <= 1'b0;
            dir_right   <= 1'b0;
            shift_count <= `MDU_RST_CNT;
            cyc_left    <= 5'h00;
            result      <= 48'h0000_0000_0000;
            res_ovf     <= 1'b0;
            res_cnt     <= `MDU_RST_CNT;
            ld_en       <= 1'b0;
        end else begin
            ld_en <= 1'b0;
            // Set wins over the clear by control read
            if (err_set) begin
                err_flag <= 1'b1;
            end else if (rd_ctrl) begin
                err_flag <= 1'b0;
            end
            if (wr_byte && sfr_sel == `MDU_SEL_B0) begin
                armed <= 1'b1;
            end else if (final_rd && !exec) begin
                armed <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (wr_byte && sfr_sel == `MDU_SEL_B0) begin
                        state     <= ST_LOAD;
                        seen_wide <= 1'b0;
                        seen_b1   <= 1'b0;
                        seen_b4   <= 1'b0;
                    end
                end
                ST_LOAD: begin
                    if (start_ok) begin
                        state    <= ST_EXEC;
                        op       <= next_op;
                        result   <= next_result;
                        res_ovf  <= next_ovf;
                        res_cnt  <= next_cnt;
                        cyc_left <= next_cyc - 5'h01;
                        if (wr_ctrl) begin
                            dir_right <= sfr_wdata[`MDU_CTRL_DIR];
                        end
                    end else if (wr_byte && sfr_sel == `MDU_SEL_B0) begin
                        seen_wide <= 1'b0;
                        seen_b1   <= 1'b0;
                        seen_b4   <= 1'b0;
                    end else if (wr_byte) begin
                        if (sfr_sel == `MDU_SEL_B2 || sfr_sel == `MDU_SEL_B3) begin
                            seen_wide <= 1'b1;
                        end
                        // The later of bytes one and four picks multiply or divide
                        if (sfr_sel == `MDU_SEL_B1) begin
                            seen_b1 <= 1'b1;
                            seen_b4 <= 1'b0;
                        end
                        if (sfr_sel == `MDU_SEL_B4) begin
                            seen_b1 <= 1'b0;
                            seen_b4 <= 1'b1;
                        end
                    end
                end
                ST_EXEC: begin
                    if (cyc_left <= 5'h01) begin
                        state       <= ST_IDLE;
                        ld_en       <= 1'b1;
                        ovf_flag    <= res_ovf;
                        shift_count <= res_cnt;
                    end else begin
                        cyc_left <= cyc_left - 5'h01;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_rdata <= 8'h00;
            rd_ctrl_q  <= 1'b0;
        end else begin
            rd_ctrl_q  <= (sfr_sel == `MDU_SEL_CTRL);
            ctrl_rdata <= {err_flag, ovf_flag, dir_right, shift_count};
        end
    end

    assign sfr_rdata = rd_ctrl_q ? ctrl_rdata : byte_rdata;
    assign busy      = exec;
endmodule // mdu_arith_coprocessor

// ### mdu_arith_coprocessor_asserts.sv
// Port-level checks for the arithmetic co-processor
`timescale 1ns/1ps
module mdu_arith_coprocessor_asserts (
    input wire       sys_clk,
    input wire       sys_rst,
    input wire       sfr_wr,
    input wire       sfr_rd,
    input wire [2:0] sfr_sel,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    input wire       busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    reg  open_seq;
    reg  s1;
    reg  s4;
    reg  s23;
    reg  err;
    wire idle_wr = sfr_wr && !busy;
    wire go5     = idle_wr && open_seq && sfr_sel == 3'h5;
    wire go6     = idle_wr && open_seq && sfr_sel == 3'h6;
    wire go      = go5 || go6;
    // ****************************************
    // Load sequence and error flag tracking
    // ****************************************
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            {open_seq, s1, s4, s23} <= 4'h0;
        end else if (idle_wr) begin
            case (sfr_sel)
                3'h0: {open_seq, s1, s4, s23} <= 4'h8;
                3'h1: {s1, s4} <= 2'h2;
                3'h4: {s1, s4} <= 2'h1;
                3'h2, 3'h3: s23 <= 1'b1;
                default: open_seq <= 1'b0;
            endcase
        end
    end
    always @(posedge sys_clk) begin
        if (sys_rst)
            err <= 1'b0;
        else if (busy && ((sfr_wr && sfr_sel != 3'h7) || (sfr_rd && sfr_sel < 3'h6)))
            err <= 1'b1;
        else if (sfr_rd && sfr_sel == 3'h6)
            err <= 1'b0;
    end
    sequence busy8;
        busy [*8];
    endsequence
    sequence ends_now;
        !busy;
    endsequence
    a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> !busy && sfr_rdata == 8'h00)
        else $error("busy or read data not cleared by reset");
    a_div32_time: assert property (go5 && s23 |=> busy8 ##1 busy8 ##1 ends_now)
        else $error("long division time wrong");
    a_div16_time: assert property (go5 && !s23 && s4 |=> busy8 ##1 ends_now)
        else $error("short division time wrong");
    a_mul_time: assert property (go5 && !s23 && s1 |=> busy [*5] ##1 busy [*5] ##1 ends_now)
        else $error("multiply time wrong");
    a_shift_one: assert property (go6 && sfr_wdata[4:0] == 5'h01 |=> busy [*2] ##1 ends_now)
        else $error("shift by one time wrong");
    a_shift_max: assert property (go6 && sfr_wdata[4:0] == 5'h1F |=> busy8 ##1 busy8 ##1 busy ##1 ends_now)
        else $error("shift by thirty-one time wrong");
    a_norm_time: assert property (go6 && sfr_wdata[4:0] == 5'h00 |=> busy [*3] ##[1:16] ends_now)
        else $error("normalize time out of range");
    a_busy_cause: assert property ($rose(busy) |-> $past(go))
        else $error("busy rose without a closing write");
    a_err_flag: assert property (sfr_sel == 3'h6 |=> sfr_rdata[7] == $past(err))
        else $error("sequence error flag wrong");
endmodule // mdu_arith_coprocessor_asserts
bind mdu_arith_coprocessor mdu_arith_coprocessor_asserts mdu_arith_coprocessor_asserts_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_sel(sfr_sel),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .busy(busy));

// ### mdu_cpu_model.sv
// Processor model issuing register accesses
`timescale 1ns/1ps
module mdu_cpu_model (
    input  wire       sys_clk,
    input  wire [7:0] sfr_rdata,
    output reg        sfr_wr,
    output reg        sfr_rd,
    output reg  [2:0] sfr_sel,
    output reg  [7:0] sfr_wdata
);
    initial begin
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_sel = 3'h7;
        sfr_wdata = 8'h00;
    end
    // Released data lines show the inverse of the last value
    task wr(input [2:0] s, input [7:0] d);
        begin
            @(negedge sys_clk);
            sfr_sel = s;
            sfr_wdata = d;
            sfr_wr = 1'b1;
            @(negedge sys_clk);
            sfr_wr = 1'b0;
            sfr_sel = 3'h7;
            sfr_wdata = ~d;
        end
    endtask
    task rd(input [2:0] s, output [7:0] d);
        begin
            @(negedge sys_clk);
            sfr_sel = s;
            sfr_rd = 1'b1;
            @(negedge sys_clk);
            d = sfr_rdata;
            sfr_rd = 1'b0;
            sfr_sel = 3'h7;
        end
    endtask
endmodule // mdu_cpu_model

// ### test_mdu_arith_coprocessor.sv
// Directed bench for the arithmetic co-processor
`timescale 1ns/1ps
module test_mdu_arith_coprocessor;
    reg        sys_clk;
    reg        sys_rst;
    wire       sfr_wr;
    wire       sfr_rd;
    wire [2:0] sfr_sel;
    wire [7:0] sfr_wdata;
    wire [7:0] sfr_rdata;
    wire       busy;
    reg  [7:0] v;
    integer    err_total;
    integer    total_checks;
    integer    i;
    mdu_arith_coprocessor mdu_arith_coprocessor_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .busy(busy));
    mdu_cpu_model mdu_cpu_model_inst (.sys_clk(sys_clk), .sfr_rdata(sfr_rdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata));
    task check(input [7:0] got, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task w(input [2:0] s, input [7:0] d);
        mdu_cpu_model_inst.wr(s, d);
    endtask
    task rchk(input [2:0] s, input [7:0] e);
        begin
            mdu_cpu_model_inst.rd(s, v);
            check(v, e);
        end
    endtask
    task chk32(input [31:0] x);
        for (i = 0; i < 4; i = i + 1)
            rchk(i[2:0], x[8*i +: 8]);
    endtask
    task flags(input [7:0] e);
        begin
            mdu_cpu_model_inst.rd(3'h6, v);
            check(v & 8'hC0, e);
        end
    endtask
    task waitd(input [7:0] e);
        integer n;
        begin
            n = 0;
            while (busy === 1'b1 && n < 60) begin
                @(negedge sys_clk);
                n = n + 1;
            end
            if (n == 60) begin
                err_total = err_total + 1;
                end_sim;
            end
            if (e != 8'hFF)
                check(n[7:0], e);
        end
    endtask
    task mulst(input [15:0] a, input [15:0] b);
        begin
            w(3'h0, a[7:0]);
            w(3'h4, b[7:0]);
            w(3'h1, a[15:8]);
            w(3'h5, b[15:8]);
        end
    endtask
    task div(input big, input [31:0] n, input [15:0] d, input [31:0] q, input [15:0] r);
        begin
            w(3'h0, n[7:0]);
            w(3'h1, n[15:8]);
            if (big) begin
                w(3'h2, n[23:16]);
                w(3'h3, n[31:24]);
            end
            w(3'h4, d[7:0]);
            w(3'h5, d[15:8]);
            waitd(big ? 8'h10 : 8'h08);
            rchk(3'h0, q[7:0]);
            rchk(3'h1, q[15:8]);
            if (big) begin
                rchk(3'h2, q[23:16]);
                rchk(3'h3, q[31:24]);
            end
            rchk(3'h4, r[7:0]);
            rchk(3'h5, r[15:8]);
        end
    endtask
    task sh(input [31:0] x, input [7:0] c, input [31:0] y, input [7:0] cyc);
        begin
            for (i = 0; i < 4; i = i + 1)
                w(i[2:0], x[8*i +: 8]);
            w(3'h6, c);
            waitd(cyc);
            chk32(y);
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        sys_rst = 1'b1;
        err_total = 0;
        total_checks = 0;
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b0;
        rchk(3'h0, 8'h00);
        rchk(3'h6, 8'h00);
        $display("test reset finished");
        mulst(16'h1234, 16'h0010);
        waitd(8'h0A);
        chk32(32'h00012340);
        flags(8'h40);
        mulst(16'h0003, 16'h0105);
        waitd(8'h0A);
        chk32(32'h0000030F);
        flags(8'h00);
        $display("test multiply finished");
        div(1'b1, 32'h00012345, 16'h0010, 32'h00001234, 16'h0005);
        flags(8'h00);
        div(1'b0, 32'h00000064, 16'h0007, 32'h0000000E, 16'h0002);
        div(1'b0, 32'h00000064, 16'h0000, 32'h00000000, 16'h0000);
        flags(8'h40);
        $display("test divide finished");
        sh(32'h80000001, 8'h01, 32'h00000002, 8'h02);
        sh(32'h80000000, 8'h3F, 32'h00000001, 8'h11);
        sh(32'h40000000, 8'h00, 32'h80000000, 8'h03);
        rchk(3'h6, 8'h01);
        sh(32'h80000000, 8'h00, 32'h80000000, 8'h03);
        rchk(3'h6, 8'h40);
        w(3'h6, 8'h00);
        flags(8'h40);
        $display("test shift and normalize finished");
        mulst(16'h0002, 16'h0003);
        mdu_cpu_model_inst.rd(3'h0, v);
        waitd(8'hFF);
        chk32(32'h00000006);
        flags(8'h80);
        flags(8'h00);
        mulst(16'h0002, 16'h0003);
        w(3'h2, 8'hAA);
        waitd(8'hFF);
        chk32(32'h00000006);
        flags(8'h80);
        $display("test sequence error finished");
        end_sim;
    end
endmodule // test_mdu_arith_coprocessor
